// *** nmi_busfault_irq_enable.sv ***
// nmi sources, bus fault causes and top-level interrupt enable registers
//
// Overview of operation
// - nmi is fed only by crystal-loss and watchdog low-water events
// - crystal dead while running on it: switch system clock to rc
// - crystal-loss flag rises only after detection and switchover finish
// - enabled watchdog unrestarted for 1.792 s raises its nmi event
// - each bus fault cause is its own sticky bit; several may set together
// - byte or half access to apb, or unaligned word access, is bad width
// - unprivileged write to system peripherals or protected ram faults
// - access past last register of a 4 kB block or past memory faults
// - fault while one is recorded sets missed bit and raises hard fault
// - writing ones to enable-set enables those interrupts; zeros do nothing
// - writing ones to enable-clear disables those interrupts; zeros nothing
// - enable bit layout 16 debug down to 0 timer one; 31..17 read zero
// - after reset all interrupts disabled; both enable registers read zero
// - nmi stays high until every unmasked event flag is cleared
`timescale 1ns/10ps
module nmi_busfault_irq_enable #(
    parameter int unsigned WDOG_LIMIT = irq_pkg::WDOG_CYCLES
) (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire irq_pkg::reg_req_t    reg_req,
    output logic [31:0]               rdata,
    input  wire logic                 xtal_alive,
    input  wire irq_pkg::bus_access_t bus_access,
    output logic [irq_pkg::IRQ_W-1:0] irq_enable,
    output logic                      nmi,
    output logic                      main_system_clock_on_xtal,
    output logic                      bus_fault_irq,
    output logic                      hard_fault
);

    localparam logic [irq_pkg::WDOG_CNT_W-1:0] WDOG_LAST =
        irq_pkg::WDOG_CNT_W'(WDOG_LIMIT - 1);

    typedef struct packed {
        logic [31:0]                   rdata;
        logic [irq_pkg::IRQ_W-1:0]     irq_enable;
        logic [1:0]                    nmi_status;
        logic [1:0]                    nmi_mask;
        logic                          nmi;
        irq_pkg::clk_state_t           clk_state;
        logic [irq_pkg::CLK_CNT_W-1:0] clk_count;
        logic                          main_system_clock_on_xtal;
        logic                          wdog_enable;
        logic [irq_pkg::WDOG_CNT_W-1:0] wdog_count;
        logic [3:0]                    fault_status;
        logic                          bus_fault_irq;
        logic                          hard_fault;
    } block_state_t;

    // ========================================================================
    // reset release
    logic [1:0]   rst_sync_reg;
    logic         rst_n;
    block_state_t state_reg;
    block_state_t state_next;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ========================================================================
    // bus fault decode
    logic        in_apb;
    logic        in_sys;
    logic        in_ram_region;
    logic        in_flash_region;
    logic        prot_ram;
    logic [2:0]  fault_cause;
    logic        any_fault;

    assign in_apb = bus_access.addr >= irq_pkg::APB_BASE &&
                    bus_access.addr <= irq_pkg::APB_TOP;
    assign in_sys = (bus_access.addr >= irq_pkg::APB_BASE &&
                     bus_access.addr <= irq_pkg::SYS_APB_TOP) ||
                    (bus_access.addr >= irq_pkg::SYS_AHB_BASE &&
                     bus_access.addr <= irq_pkg::SYS_AHB_TOP);
    assign in_ram_region = bus_access.addr >= irq_pkg::RAM_BASE &&
                           bus_access.addr <= irq_pkg::RAM_REGION_TOP;
    assign in_flash_region = bus_access.addr < irq_pkg::RAM_BASE;
    assign prot_ram = bus_access.addr >= irq_pkg::RAM_BASE &&
                      bus_access.addr <= irq_pkg::RAM_PROT_TOP;

    assign fault_cause[irq_pkg::BAD_WIDTH_BIT] = bus_access.valid &&
        ((in_apb && bus_access.size != irq_pkg::SIZE_WORD) ||
         (bus_access.size == irq_pkg::SIZE_WORD &&
          bus_access.addr[1:0] != 2'b00));
    assign fault_cause[irq_pkg::PROTECTION_BIT] = bus_access.valid &&
        bus_access.write && !bus_access.privileged && (in_sys || prot_ram);
    // holes above last register and past memory tops
    assign fault_cause[irq_pkg::UNMAPPED_BIT] = bus_access.valid &&
        ((in_apb && bus_access.addr[11:0] > irq_pkg::PERIPH_LAST_REG) ||
         (in_ram_region && bus_access.addr > irq_pkg::RAM_TOP) ||
         (in_flash_region && bus_access.addr > irq_pkg::FLASH_TOP));
    assign any_fault = |fault_cause;

    // ========================================================================
    // next state
    logic [1:0] nmi_event;
    logic [3:0] fault_clear;
    logic [1:0] nmi_clear;
    logic       wdog_restart;

    always_comb begin
        state_next = state_reg;
        nmi_event = 2'b00;
        nmi_clear = 2'b00;
        fault_clear = 4'h0;
        wdog_restart = 1'b0;
        state_next.rdata = irq_pkg::RESET_VALUE;
        state_next.hard_fault = 1'b0;

        if (reg_req.wr) begin
            case (reg_req.addr)
                irq_pkg::IRQ_ENABLE_SET_ADDR: begin
                    state_next.irq_enable = state_reg.irq_enable |
                        reg_req.wdata[irq_pkg::IRQ_W-1:0];
                end
                irq_pkg::IRQ_ENABLE_CLEAR_ADDR: begin
                    state_next.irq_enable = state_reg.irq_enable &
                        ~reg_req.wdata[irq_pkg::IRQ_W-1:0];
                end
                irq_pkg::NMI_STATUS_ADDR: begin
                    nmi_clear = reg_req.wdata[1:0];
                end
                irq_pkg::NMI_MASK_ADDR: begin
                    state_next.nmi_mask = reg_req.wdata[1:0];
                end
                irq_pkg::WDOG_CTRL_ADDR: begin
                    state_next.wdog_enable =
                        reg_req.wdata[irq_pkg::WDOG_ENABLE_BIT];
                end
                irq_pkg::WDOG_RESTART_ADDR: begin
                    wdog_restart = 1'b1;
                end
                irq_pkg::FAULT_STATUS_ADDR: begin
                    fault_clear = reg_req.wdata[3:0];
                end
                default: begin
                end
            endcase
        end

        // loss detection and switch to the rc oscillator
        case (state_reg.clk_state)
            irq_pkg::CLK_ON_XTAL: begin
                if (xtal_alive) begin
                    state_next.clk_count = '0;
                end else if (state_reg.clk_count == irq_pkg::XTAL_LAST) begin
                    state_next.clk_state = irq_pkg::CLK_SWITCHING;
                    state_next.main_system_clock_on_xtal = 1'b0;
                    state_next.clk_count = '0;
                end else begin
                    state_next.clk_count = state_reg.clk_count + 5'h01;
                end
            end
            // event only once the switch has settled
            irq_pkg::CLK_SWITCHING: begin
                if (state_reg.clk_count == irq_pkg::SWITCH_LAST) begin
                    state_next.clk_state = irq_pkg::CLK_ON_RC;
                    state_next.clk_count = '0;
                    nmi_event[irq_pkg::NMI_XTAL_BIT] = 1'b1;
                end else begin
                    state_next.clk_count = state_reg.clk_count + 5'h01;
                end
            end
            irq_pkg::CLK_ON_RC: begin
                // a return to the crystal is only honoured while it runs
                if (reg_req.wr && reg_req.addr == irq_pkg::CLOCK_CTRL_ADDR &&
                    reg_req.wdata[irq_pkg::CLOCK_USE_XTAL_BIT] && xtal_alive)
                begin
                    state_next.clk_state = irq_pkg::CLK_ON_XTAL;
                    state_next.main_system_clock_on_xtal = 1'b1;
                end
                state_next.clk_count = '0;
            end
            default: begin
                state_next.clk_state = irq_pkg::CLK_ON_RC;
                state_next.main_system_clock_on_xtal = 1'b0;
                state_next.clk_count = '0;
            end
        endcase

        // low-water mark; count saturates until restarted
        if (!state_reg.wdog_enable || wdog_restart) begin
            state_next.wdog_count = '0;
        end else if (state_reg.wdog_count != WDOG_LAST) begin
            state_next.wdog_count = state_reg.wdog_count + 26'h0000001;
            if (state_reg.wdog_count == WDOG_LAST - 26'h0000001) begin
                nmi_event[irq_pkg::NMI_WDOG_BIT] = 1'b1;
            end
        end

        // only these two events reach the nmi; set beats clear
        state_next.nmi_status = (state_reg.nmi_status & ~nmi_clear) |
                                nmi_event;
        state_next.nmi = |(state_next.nmi_status & state_next.nmi_mask);

        // sticky causes, write one to clear, new cause wins
        state_next.fault_status = (state_reg.fault_status & ~fault_clear) |
                                  {1'b0, fault_cause};
        // second fault: missed bit plus hard fault
        if (any_fault && |state_reg.fault_status[2:0]) begin
            state_next.fault_status[irq_pkg::MISSED_BIT] = 1'b1;
            state_next.hard_fault = 1'b1;
        end
        state_next.bus_fault_irq = |state_next.fault_status[2:0];

        if (reg_req.rd) begin
            case (reg_req.addr)
                // both addresses return the live enable state
                irq_pkg::IRQ_ENABLE_SET_ADDR,
                irq_pkg::IRQ_ENABLE_CLEAR_ADDR: begin
                    state_next.rdata = {15'h0000, state_reg.irq_enable};
                end
                irq_pkg::NMI_STATUS_ADDR: begin
                    state_next.rdata = {30'h00000000, state_reg.nmi_status};
                end
                irq_pkg::NMI_MASK_ADDR: begin
                    state_next.rdata = {30'h00000000, state_reg.nmi_mask};
                end
                irq_pkg::CLOCK_CTRL_ADDR: begin
                    state_next.rdata = {31'h00000000,
                                        state_reg.main_system_clock_on_xtal};
                end
                irq_pkg::WDOG_CTRL_ADDR: begin
                    state_next.rdata = {31'h00000000, state_reg.wdog_enable};
                end
                irq_pkg::FAULT_STATUS_ADDR: begin
                    state_next.rdata = {28'h0000000, state_reg.fault_status};
                end
                default: begin
                    state_next.rdata = irq_pkg::RESET_VALUE;
                end
            endcase
        end
    end

    // ========================================================================
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        // everything, enables included, clears to zero
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata          = state_reg.rdata;
    assign irq_enable     = state_reg.irq_enable;
    assign nmi            = state_reg.nmi;
    assign main_system_clock_on_xtal = state_reg.main_system_clock_on_xtal;
    assign bus_fault_irq  = state_reg.bus_fault_irq;
    assign hard_fault     = state_reg.hard_fault;

    // ========================================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence xtal_lost_s;
        state_reg.clk_state == irq_pkg::CLK_ON_XTAL && !xtal_alive &&
        state_reg.clk_count == irq_pkg::XTAL_LAST;
    endsequence

    sequence switch_done_s;
        !main_system_clock_on_xtal && state_reg.clk_state == irq_pkg::CLK_SWITCHING
        ##4 state_reg.nmi_status[irq_pkg::NMI_XTAL_BIT];
    endsequence

    enable_set_a: assert property (
        reg_req.wr && reg_req.addr == irq_pkg::IRQ_ENABLE_SET_ADDR
        |=> (irq_enable & $past(reg_req.wdata[16:0])) ==
            $past(reg_req.wdata[16:0]) &&
            (irq_enable & ~$past(reg_req.wdata[16:0])) ==
            ($past(irq_enable) & ~$past(reg_req.wdata[16:0])))
        else $error("enable set write wrong");

    enable_clear_a: assert property (
        reg_req.wr && reg_req.addr == irq_pkg::IRQ_ENABLE_CLEAR_ADDR
        |=> irq_enable == ($past(irq_enable) & ~$past(reg_req.wdata[16:0])))
        else $error("enable clear write wrong");

    enable_read_a: assert property (
        reg_req.rd && (reg_req.addr == irq_pkg::IRQ_ENABLE_SET_ADDR ||
                       reg_req.addr == irq_pkg::IRQ_ENABLE_CLEAR_ADDR)
        |=> rdata == {15'h0000, $past(irq_enable)})
        else $error("enable readback wrong");

    upper_zero_a: assert property (
        rdata[31:17] == 15'h0000 || !$past(reg_req.addr[31:28] == 4'hE))
        else $error("upper enable bits not zero");

    xtal_order_a: assert property (
        xtal_lost_s |=> switch_done_s)
        else $error("crystal event not after switchover");

    xtal_switch_a: assert property (
        $fell(main_system_clock_on_xtal) |-> $past(!xtal_alive, 1) &&
        $past(state_reg.clk_count) == irq_pkg::XTAL_LAST)
        else $error("clock switched without loss");

    wdog_fire_a: assert property (
        state_reg.wdog_enable && !wdog_restart &&
        state_reg.wdog_count == WDOG_LAST - 26'h0000001
        |=> state_reg.nmi_status[irq_pkg::NMI_WDOG_BIT] ##1 state_reg.nmi ||
            !state_reg.nmi_mask[irq_pkg::NMI_WDOG_BIT])
        else $error("watchdog low water missed");

    nmi_level_a: assert property (
        nmi && !(reg_req.wr && (reg_req.addr == irq_pkg::NMI_STATUS_ADDR ||
                                reg_req.addr == irq_pkg::NMI_MASK_ADDR))
        |=> nmi)
        else $error("nmi dropped while its flag was still set");

    width_fault_a: assert property (
        bus_access.valid && in_apb && bus_access.size != irq_pkg::SIZE_WORD
        |=> state_reg.fault_status[irq_pkg::BAD_WIDTH_BIT] && bus_fault_irq)
        else $error("bad width fault not recorded");

    missed_fault_a: assert property (
        any_fault && |state_reg.fault_status[2:0]
        |=> state_reg.fault_status[irq_pkg::MISSED_BIT] && hard_fault
        ##1 !hard_fault || $past(any_fault))
        else $error("second fault not flagged");

    fault_sticky_a: assert property (
        state_reg.fault_status[irq_pkg::UNMAPPED_BIT] &&
        !(reg_req.wr && reg_req.addr == irq_pkg::FAULT_STATUS_ADDR)
        |=> state_reg.fault_status[irq_pkg::UNMAPPED_BIT])
        else $error("fault cause lost");

endmodule

// *** irq_pkg.sv ***
// constants, types and register map of the interrupt enable and fault block
package irq_pkg;

    // ========================================================================
    // clock and timing
    localparam int unsigned CLK_HZ            = 20_000_000;
    localparam int unsigned CLK_PERIOD_NS     = 50;
    localparam int unsigned XTAL_LOSS_NS      = 1000;
    localparam int unsigned XTAL_LOSS_CYCLES  =
        (XTAL_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SWITCH_SETTLE_NS  = 200;
    localparam int unsigned SWITCH_CYCLES     =
        (SWITCH_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WDOG_LOW_WATER_MS = 1792;
    localparam int unsigned WDOG_CYCLES       =
        WDOG_LOW_WATER_MS * (CLK_HZ / 1000);
    localparam int unsigned CLK_CNT_W         = 5;
    localparam int unsigned WDOG_CNT_W        = 26;
    localparam logic [4:0]  XTAL_LAST         = 5'(XTAL_LOSS_CYCLES - 1);
    localparam logic [4:0]  SWITCH_LAST       = 5'(SWITCH_CYCLES - 1);

    // ========================================================================
    // register map
    localparam logic [31:0] IRQ_ENABLE_SET_ADDR   = 32'hE000E100;
    localparam logic [31:0] IRQ_ENABLE_CLEAR_ADDR = 32'hE000E180;
    localparam logic [31:0] NMI_STATUS_ADDR       = 32'h4000A000;
    localparam logic [31:0] NMI_MASK_ADDR         = 32'h4000A004;
    localparam logic [31:0] CLOCK_CTRL_ADDR       = 32'h4000A008;
    localparam logic [31:0] WDOG_CTRL_ADDR        = 32'h4000A00C;
    localparam logic [31:0] WDOG_RESTART_ADDR     = 32'h4000A010;
    localparam logic [31:0] FAULT_STATUS_ADDR     = 32'h4000A014;
    localparam logic [31:0] RESET_VALUE           = 32'h00000000;

    // ========================================================================
    // field positions
    localparam int unsigned IRQ_W                 = 17;
    localparam int unsigned DEBUG_IRQ_BIT         = 16;
    localparam int unsigned EXT_PIN_D_IRQ_BIT     = 15;
    localparam int unsigned EXT_PIN_C_IRQ_BIT     = 14;
    localparam int unsigned EXT_PIN_B_IRQ_BIT     = 13;
    localparam int unsigned EXT_PIN_A_IRQ_BIT     = 12;
    localparam int unsigned CONVERTER_IRQ_BIT     = 11;
    localparam int unsigned MAC_RECEIVE_IRQ_BIT   = 10;
    localparam int unsigned MAC_TRANSMIT_IRQ_BIT  = 9;
    localparam int unsigned MAC_TIMER_IRQ_BIT     = 8;
    localparam int unsigned SECURITY_IRQ_BIT      = 7;
    localparam int unsigned SERIAL_TWO_IRQ_BIT    = 6;
    localparam int unsigned SERIAL_ONE_IRQ_BIT    = 5;
    localparam int unsigned SLEEP_TIMER_IRQ_BIT   = 4;
    localparam int unsigned BASEBAND_IRQ_BIT      = 3;
    localparam int unsigned MANAGEMENT_IRQ_BIT    = 2;
    localparam int unsigned TIMER_TWO_IRQ_BIT     = 1;
    localparam int unsigned TIMER_ONE_IRQ_BIT     = 0;
    localparam int unsigned NMI_XTAL_BIT          = 0;
    localparam int unsigned NMI_WDOG_BIT          = 1;
    localparam int unsigned BAD_WIDTH_BIT         = 0;
    localparam int unsigned PROTECTION_BIT        = 1;
    localparam int unsigned UNMAPPED_BIT          = 2;
    localparam int unsigned MISSED_BIT            = 3;
    localparam int unsigned CLOCK_USE_XTAL_BIT    = 0;
    localparam int unsigned WDOG_ENABLE_BIT       = 0;

    // ========================================================================
    // watched address space
    localparam logic [31:0] FLASH_TOP        = 32'h0001FFFF;
    localparam logic [31:0] RAM_BASE         = 32'h20000000;
    localparam logic [31:0] RAM_TOP          = 32'h20002FFF;
    localparam logic [31:0] RAM_REGION_TOP   = 32'h3FFFFFFF;
    localparam logic [31:0] RAM_PROT_TOP     = 32'h200003FF;
    localparam logic [31:0] APB_BASE         = 32'h40000000;
    localparam logic [31:0] APB_TOP          = 32'h4000FFFF;
    localparam logic [31:0] SYS_APB_TOP      = 32'h40003FFF;
    localparam logic [31:0] SYS_AHB_BASE     = 32'h40010000;
    localparam logic [31:0] SYS_AHB_TOP      = 32'h4001FFFF;
    localparam logic [11:0] PERIPH_LAST_REG  = 12'h0FC;

    // ========================================================================
    // types
    typedef enum logic [1:0] {
        SIZE_BYTE = 2'b00,
        SIZE_HALF = 2'b01,
        SIZE_WORD = 2'b10
    } access_size_t;

    typedef enum logic [1:0] {
        CLK_ON_RC     = 2'b00,
        CLK_ON_XTAL   = 2'b01,
        CLK_SWITCHING = 2'b10
    } clk_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [31:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic         valid;
        logic         write;
        logic         privileged;
        access_size_t size;
        logic [31:0]  addr;
    } bus_access_t;

endpackage

// *** core_model.sv ***
// processor core model driving the register port of the block
`timescale 1ns/10ps
module core_model (
    input  wire logic         clk,
    input  wire logic [31:0]  rdata,
    output irq_pkg::reg_req_t req
);
    // ========================================================================
    // bus cycles
    initial begin
        req = '0;
    end

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        // released lines are scrambled so a stale value never looks held
        req <= '{1'b0, 1'b0, ~a, ~d};
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk);
        req <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge clk);
        req <= '{1'b0, 1'b0, ~a, 32'hFFFFFFFF};
        #1;
        d = rdata;
    endtask
endmodule

// *** nmi_busfault_irq_enable_tb.sv ***
// self-checking bench for the nmi, bus fault and enable block
`timescale 1ns/10ps
module nmi_busfault_irq_enable_tb;
    logic                      clk = 1'b0;
    logic                      reset_n = 1'b0;
    logic                      xtal_alive = 1'b1;
    irq_pkg::reg_req_t         req;
    irq_pkg::bus_access_t      acc = '0;
    logic [31:0]               rdata;
    logic [irq_pkg::IRQ_W-1:0] irq_enable;
    logic                      nmi;
    logic                      on_xtal;
    logic                      bf_irq;
    logic                      hard_fault;
    int                        bad_count = 0;
    int                        checks = 0;
    int                        c;

    always #25 clk = ~clk;

    core_model core_u (.clk(clk), .rdata(rdata), .req(req));

    // watchdog limit cut down so the run stays short
    nmi_busfault_irq_enable #(.WDOG_LIMIT(50)) dut_u (
        .clk(clk), .reset_n(reset_n), .reg_req(req), .rdata(rdata),
        .xtal_alive(xtal_alive), .bus_access(acc),
        .irq_enable(irq_enable), .nmi(nmi), .main_system_clock_on_xtal(on_xtal),
        .bus_fault_irq(bf_irq), .hard_fault(hard_fault));

    // ========================================================================
    // helpers
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        core_u.rd(a, d);
        chk(d, exp);
    endtask

    task automatic wait_lvl(input bit sel, input logic v, input int n);
        c = 0;
        while (((sel ? nmi : on_xtal) !== v) && c < n) begin
            @(posedge clk);
            #1;
            c++;
        end
        if (c >= n) begin
            bad_count++;
            $display("ERROR %0t: wait ran out", $time);
            print_verdict();
        end
    endtask

    task automatic flt(input logic w, input logic p, input logic [1:0] s,
                       input logic [31:0] a, input logic [31:0] exp,
                       input bit clear);
        @(posedge clk);
        acc <= '{1'b1, w, p, irq_pkg::access_size_t'(s), a};
        @(posedge clk);
        acc <= '{1'b0, ~w, ~p, irq_pkg::SIZE_WORD, ~a};
        #1;
        chk(hard_fault, exp[3]);
        chk(bf_irq, 1'b1);
        rchk(32'h4000A014, exp);
        if (clear) begin
            core_u.wr(32'h4000A014, 32'hF);
            #1;
            chk(bf_irq, 1'b0);
        end
    endtask

    // ========================================================================
    // scenarios
    task automatic sc_regs();
        rchk(32'hE000E100, 32'h0);
        rchk(32'hE000E180, 32'h0);
        @(posedge clk);
        #1;
        chk(rdata, 32'h0);
        core_u.wr(32'hE000E100, 32'hFFFFFFFF);
        rchk(32'hE000E100, 32'h0001FFFF);
        core_u.wr(32'hE000E180, 32'h0000AAAA);
        core_u.wr(32'hE000E100, 32'h0);
        rchk(32'hE000E180, 32'h00015555);
        rchk(32'hE000E100, 32'h00015555);
        core_u.wr(32'hE000E180, 32'h0);
        #1;
        chk(irq_enable, 32'h00015555);
        core_u.wr(32'h4000A100, 32'hFFFFFFFF);
        rchk(32'h4000A100, 32'h0);
    endtask

    task automatic sc_faults();
        flt(0, 1, 2'b00, 32'h40000000, 32'h1, 0);
        flt(0, 1, 2'b00, 32'h40000004, 32'h9, 1);
        flt(0, 1, 2'b10, 32'h20000402, 32'h1, 1);
        flt(0, 1, 2'b01, 32'h40004000, 32'h1, 1);
        flt(1, 0, 2'b10, 32'h40000000, 32'h2, 1);
        flt(1, 0, 2'b10, 32'h20000010, 32'h2, 1);
        flt(1, 0, 2'b10, 32'h40010000, 32'h2, 1);
        flt(0, 1, 2'b10, 32'h40000100, 32'h4, 1);
        flt(0, 1, 2'b10, 32'h20003000, 32'h4, 1);
        flt(0, 1, 2'b10, 32'h00020000, 32'h4, 1);
        flt(1, 0, 2'b00, 32'h40000101, 32'h7, 1);
    endtask

    task automatic sc_xtal();
        core_u.wr(32'h4000A004, 32'h3);
        core_u.wr(32'h4000A008, 32'h1);
        #1;
        chk(on_xtal, 1'b1);
        @(posedge clk);
        xtal_alive <= 1'b0;
        wait_lvl(1'b0, 1'b0, 40);
        chk(c, irq_pkg::XTAL_LOSS_CYCLES);
        chk(nmi, 1'b0);
        wait_lvl(1'b1, 1'b1, 8);
        chk(c, irq_pkg::SWITCH_CYCLES);
        rchk(32'h4000A000, 32'h1);
        repeat (10) @(posedge clk);
        #1;
        chk(nmi, 1'b1);
        core_u.wr(32'h4000A000, 32'h1);
        #1;
        chk(nmi, 1'b0);
        @(posedge clk);
        xtal_alive <= 1'b1;
    endtask

    task automatic sc_wdog();
        core_u.wr(32'h4000A00C, 32'h1);
        repeat (3) begin
            repeat (30) @(posedge clk);
            core_u.wr(32'h4000A010, 32'h0);
        end
        #1;
        chk(nmi, 1'b0);
        wait_lvl(1'b1, 1'b1, 60);
        chk(32'(c > 40), 32'h1);
        rchk(32'h4000A000, 32'h2);
        // masking the source must drop the line while status stays set
        core_u.wr(32'h4000A004, 32'h0);
        #1;
        chk(nmi, 1'b0);
        core_u.wr(32'h4000A00C, 32'h0);
        core_u.wr(32'h4000A000, 32'h2);
        rchk(32'h4000A000, 32'h0);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        sc_regs();
        sc_faults();
        sc_xtal();
        sc_wdog();
        print_verdict();
    end
endmodule
